// ### acd_pkg.sv
package acd_pkg;

    // Widths and depths.
    localparam int BYTE_W = 8;
    localparam int RES_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int PTR_W = 4;
    localparam int CNT_W = 5;
    localparam int CH_W = 4;
    localparam int FRAME_BITS = 16;
    localparam int LEAD_ZEROS = 4;

    // Power-up values of the stored command bytes.
    localparam logic [7:0] CONV_RST = 8'h00;
    localparam logic [7:0] SETUP_RST = 8'h20;
    localparam logic [7:0] AVG_RST = 8'h00;

    // Leading select bits of a command byte.
    localparam int CONV_SEL_BIT = 7;
    localparam int SETUP_SEL_BIT = 6;
    localparam int AVG_SEL_BIT = 5;
    localparam int RSTC_SEL_BIT = 4;

    // Field positions.
    localparam int CH_HI = 6;
    localparam int CH_LO = 3;
    localparam int SWEEP_HI = 2;
    localparam int SWEEP_LO = 1;
    localparam int CLK_HI = 5;
    localparam int CLK_LO = 4;
    localparam int REFC_HI = 3;
    localparam int REFC_LO = 2;
    localparam int AVG_EN_BIT = 4;
    localparam int AVGN_HI = 3;
    localparam int AVGN_LO = 2;
    localparam int REP_HI = 1;
    localparam int REP_LO = 0;
    localparam int FIFO_ONLY_BIT = 3;

    // Scan modes.
    localparam logic [1:0] SWEEP_UPTO = 2'h0;
    localparam logic [1:0] SWEEP_FROM = 2'h1;
    localparam logic [1:0] SWEEP_REPEAT = 2'h2;
    localparam logic [1:0] SWEEP_ONCE = 2'h3;

    // Clock modes.
    localparam logic [1:0] CLK_INT_AUTO = 2'h0;
    localparam logic [1:0] CLK_INT_PIN = 2'h1;
    localparam logic [1:0] CLK_INT_CMD = 2'h2;
    localparam logic [1:0] CLK_EXT_SCLK = 2'h3;

    // Reference modes.
    localparam logic [1:0] REF_INT_AUTO = 2'h0;
    localparam logic [1:0] REF_EXT = 2'h1;
    localparam logic [1:0] REF_INT_ON = 2'h2;
    localparam logic [1:0] REF_RSVD = 2'h3;

    // Synchroniser order: chip select, convert start, byte toggle, word toggle.
    localparam logic [3:0] SYNC_RST = 4'hc;
    localparam int SY_CS = 3;
    localparam int SY_CNV = 2;
    localparam int SY_BYTE = 1;
    localparam int SY_WORD = 0;

    typedef enum logic [1:0] {
        WS_IDLE = 2'b01,
        WS_HELD = 2'b10
    } acd_wstate_t;

endpackage

// ### acd_decoder.sv
`timescale 1ns/1ps
// Overview of operation
// RULE1 - Bit 7 set stores conversion byte.
// RULE2 - Conversion bits 6:3 give channel N.
// RULE3 - Scan 00 is 0..N, 01 is N..top.
// RULE4 - Scan 10 repeats N, 11 converts once.
// RULE5 - Bits 7:6 at 01 store setup byte.
// RULE6 - Clock 00/01 use pin as convert start.
// RULE7 - Clock 10/11 use pin as analog input.
// RULE8 - Setup bits 3:2 choose reference mode.
// RULE9 - Bits 7:5 at 001 store averaging byte.
// RULE10 - Averaging off gives one conversion each.
// RULE11 - Average count 4, 8, 16 or 32.
// RULE12 - Repeat scan yields 4, 8, 12, 16 results.
// RULE13 - Bits 7:4 at 0001 is reset command.
// RULE14 - Bit 3 clears FIFO, else full reset.
// RULE15 - Everything powers up in shutdown.
// RULE16 - Registers reset to zero, clock mode 10.
// RULE17 - Result framed by four zeros each side.
// RULE18 - Serial input sampled on rising SCLK.
// RULE19 - Serial output changes on falling SCLK.
// RULE20 - Start by pin or by conversion byte.
// RULE21 - Sixteen-entry FIFO overwrites oldest when full.
// RULE22 - Empty FIFO shifts out zeros.
// RULE23 - End of conversion cleared by select lows.
// RULE24 - Clock mode 11 never averages.
// RULE25 - Reference value 11 is reserved.
// RULE26 - Host avoids channels above the variant.
module acd_decoder #(
    parameter int NUM_CHANNELS = 16
) (
    // System clock, reset and enable.
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic CE,
    // Serial link pins.
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic DIN,
    output logic DOUT,
    // Shared convert-start pin.
    input wire logic CONVERT_START_N,
    // Converter results and sequencer status.
    input wire logic RESULT_VALID,
    input wire logic [7:0] RESULT_DATA,
    input wire logic SCAN_DONE,
    // Decoded configuration.
    output logic [3:0] CHANNEL_NUMBER,
    output logic [1:0] SWEEP_KIND,
    output logic [3:0] SCAN_FIRST,
    output logic [3:0] SCAN_LAST,
    output logic [4:0] RESULT_COUNT,
    output logic [1:0] CLOCKING_CHOICE,
    output logic CONVERT_START_PIN_EN,
    output logic [1:0] REFERENCE_CHOICE,
    output logic REF_POWER_ON,
    output logic AVERAGING_ENABLE,
    output logic [5:0] AVG_CONVERSIONS,
    output logic [4:0] REPEAT_RESULT_COUNT,
    // Conversion control and status.
    output logic START_SCAN,
    output logic EOC_N,
    output logic [4:0] FIFO_LEVEL
);

    localparam logic [3:0] TOP_CH = 4'(NUM_CHANNELS - 1);

    function automatic logic [3:0] acd_agree(input logic [3:0] s2, input logic [3:0] s3,
                                             input logic [3:0] prev);
        acd_agree = (s2 & s3) | (prev & (s2 ^ s3));
    endfunction

    function automatic logic acd_frame_bit(input logic [7:0] res, input logic [3:0] pos);
        logic [3:0] idx;
        idx = 4'd11 - pos;
        acd_frame_bit = (pos >= 4'd4 && pos <= 4'd11) ? res[idx[2:0]] : 1'b0;
    endfunction

    // SCLK domain: receive shifter, cleared by the frame's own select.
    logic [2:0] rx_cnt_reg;
    logic [6:0] rx_sh_reg;
    logic [7:0] rx_byte_reg;
    logic rx_tgl_reg;
    logic [3:0] tx_cnt_reg;
    logic tx_tgl_reg;
    logic dout_reg;
    logic [7:0] tx_res_reg;

    always_ff @(posedge SCLK or posedge CS_N) begin
        if (CS_N) begin
            rx_cnt_reg <= 3'h0;
            rx_sh_reg <= 7'h00;
        end else begin
            rx_cnt_reg <= rx_cnt_reg + 3'h1;
            rx_sh_reg <= {rx_sh_reg[5:0], DIN}; // [RULE18]
        end
    end

    // The byte stays put for eight more edges, so the toggle alone crosses.
    always_ff @(posedge SCLK or negedge NRST) begin
        if (!NRST) begin
            rx_byte_reg <= 8'h00;
            rx_tgl_reg <= 1'b0;
        end else if (!CS_N && rx_cnt_reg == 3'h7) begin
            rx_byte_reg <= {rx_sh_reg, DIN}; // [RULE18]
            rx_tgl_reg <= ~rx_tgl_reg;
        end
    end

    // The frame position is not cleared by select, so a word read in two bytes keeps its place.
    wire [3:0] tx_pos_next = tx_cnt_reg + 4'h1;

    always_ff @(negedge SCLK or negedge NRST) begin
        if (!NRST) begin
            tx_cnt_reg <= 4'h0;
            tx_tgl_reg <= 1'b0;
            dout_reg <= 1'b0;
        end else if (!CS_N) begin
            tx_cnt_reg <= tx_pos_next;
            dout_reg <= acd_frame_bit(tx_res_reg, tx_pos_next); // [RULE19] [RULE17]
            if (tx_cnt_reg == 4'hf) begin
                tx_tgl_reg <= ~tx_tgl_reg;
            end
        end
    end

    assign DOUT = dout_reg;

    // REF_CLK domain: three-stage synchronisers, accepted once stages two and three agree.
    logic [3:0] s1_reg;
    logic [3:0] s2_reg;
    logic [3:0] s3_reg;
    logic [3:0] stab_reg;
    wire [3:0] async_in = {CS_N, CONVERT_START_N, rx_tgl_reg, tx_tgl_reg};
    wire [3:0] stab_next = acd_agree(s2_reg, s3_reg, stab_reg);

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            s1_reg <= acd_pkg::SYNC_RST;
            s2_reg <= acd_pkg::SYNC_RST;
            s3_reg <= acd_pkg::SYNC_RST;
            stab_reg <= acd_pkg::SYNC_RST;
        end else if (CE) begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            stab_reg <= stab_next;
        end
    end

    wire cs_fall = stab_reg[acd_pkg::SY_CS] & ~stab_next[acd_pkg::SY_CS];
    wire cnv_fall = stab_reg[acd_pkg::SY_CNV] & ~stab_next[acd_pkg::SY_CNV];
    wire byte_ev = stab_reg[acd_pkg::SY_BYTE] ^ stab_next[acd_pkg::SY_BYTE];
    wire word_ev = stab_reg[acd_pkg::SY_WORD] ^ stab_next[acd_pkg::SY_WORD];

    // Command byte decode by leading bits.
    logic [7:0] conv_reg;
    logic [7:0] setup_reg;
    logic [7:0] avg_reg;
    wire [7:0] cb = rx_byte_reg;
    wire is_conv = byte_ev & cb[acd_pkg::CONV_SEL_BIT]; // [RULE1]
    wire is_setup = byte_ev & (cb[7:acd_pkg::SETUP_SEL_BIT] == 2'b01); // [RULE5]
    wire is_avg = byte_ev & (cb[7:acd_pkg::AVG_SEL_BIT] == 3'b001); // [RULE9]
    wire is_rstc = byte_ev & (cb[7:acd_pkg::RSTC_SEL_BIT] == 4'b0001); // [RULE13]
    // Channels the variant lacks are dropped rather than stored.
    wire ch_ok = cb[acd_pkg::CH_HI:acd_pkg::CH_LO] <= TOP_CH; // [RULE26]
    wire conv_wr = is_conv & ch_ok;
    wire full_rst = is_rstc & ~cb[acd_pkg::FIFO_ONLY_BIT]; // [RULE14]
    wire fifo_clr = is_rstc; // [RULE14]
    wire ref_rsvd = cb[acd_pkg::REFC_HI:acd_pkg::REFC_LO] == acd_pkg::REF_RSVD;
    // A reserved reference value keeps the previous reference field.
    wire [1:0] ref_wr = ref_rsvd ? setup_reg[acd_pkg::REFC_HI:acd_pkg::REFC_LO]
                                 : cb[acd_pkg::REFC_HI:acd_pkg::REFC_LO]; // [RULE25] [RULE8]

    wire [7:0] conv_next = full_rst ? acd_pkg::CONV_RST :
                           conv_wr ? {cb[7:1], 1'b0} : conv_reg; // [RULE1] [RULE16]
    wire [7:0] setup_next = full_rst ? acd_pkg::SETUP_RST :
                            is_setup ? {cb[7:4], ref_wr, 2'b00} : setup_reg; // [RULE5] [RULE16]
    wire [7:0] avg_next = full_rst ? acd_pkg::AVG_RST :
                          is_avg ? cb : avg_reg; // [RULE9] [RULE16]

    wire [3:0] ch_n = conv_next[acd_pkg::CH_HI:acd_pkg::CH_LO]; // [RULE2]
    wire [1:0] sweep_n = conv_next[acd_pkg::SWEEP_HI:acd_pkg::SWEEP_LO];
    wire [1:0] clk_n = setup_next[acd_pkg::CLK_HI:acd_pkg::CLK_LO];
    wire [1:0] clk_cur = setup_reg[acd_pkg::CLK_HI:acd_pkg::CLK_LO];
    wire [1:0] navg_n = avg_next[acd_pkg::AVGN_HI:acd_pkg::AVGN_LO];
    wire [1:0] nrep_n = avg_next[acd_pkg::REP_HI:acd_pkg::REP_LO];

    wire [3:0] first_n = (sweep_n == acd_pkg::SWEEP_UPTO) ? 4'h0 : ch_n; // [RULE3]
    wire [3:0] last_n = (sweep_n == acd_pkg::SWEEP_FROM) ? TOP_CH : ch_n; // [RULE3] [RULE4]
    wire [4:0] rep_n = {3'(nrep_n) + 3'h1, 2'b00}; // [RULE12]
    wire [4:0] span_n = 5'(last_n) - 5'(first_n) + 5'h1;
    wire [4:0] count_n = (sweep_n == acd_pkg::SWEEP_REPEAT) ? rep_n :
                         (sweep_n == acd_pkg::SWEEP_ONCE) ? 5'h01 : span_n; // [RULE4]
    wire avg_on_n = avg_next[acd_pkg::AVG_EN_BIT] && clk_n != acd_pkg::CLK_EXT_SCLK; // [RULE24]
    wire [5:0] avgc_n = avg_on_n ? (6'h04 << navg_n) : 6'h01; // [RULE10] [RULE11]

    // A write starts a scan in the command modes, the pin does in the pin modes.
    wire start_next = (conv_wr & clk_cur[1]) | (cnv_fall & ~clk_cur[1]); // [RULE20]

    logic [3:0] first_reg;
    logic [3:0] last_reg;
    logic [4:0] count_reg;
    logic [5:0] avgc_reg;
    logic [4:0] rep_reg;
    logic start_reg;
    logic eoc_n_reg;

    // Completion outranks a clear in the same cycle.
    wire eoc_n_next = (clk_n == acd_pkg::CLK_EXT_SCLK) ? 1'b1 :
                      SCAN_DONE ? 1'b0 :
                      (cs_fall | cnv_fall) ? 1'b1 : eoc_n_reg; // [RULE23]

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            conv_reg <= acd_pkg::CONV_RST; // [RULE16]
            setup_reg <= acd_pkg::SETUP_RST; // [RULE16]
            avg_reg <= acd_pkg::AVG_RST; // [RULE16]
            first_reg <= 4'h0;
            last_reg <= 4'h0;
            count_reg <= 5'h01;
            avgc_reg <= 6'h01;
            rep_reg <= 5'h04;
            start_reg <= 1'b0; // [RULE15]
            eoc_n_reg <= 1'b1;
        end else if (CE) begin
            conv_reg <= conv_next;
            setup_reg <= setup_next;
            avg_reg <= avg_next;
            first_reg <= first_n;
            last_reg <= last_n;
            count_reg <= count_n;
            avgc_reg <= avgc_n;
            rep_reg <= rep_n;
            start_reg <= start_next;
            eoc_n_reg <= eoc_n_next;
        end
    end

    // Result FIFO with overwrite of the oldest entry.
    logic [7:0] mem [acd_pkg::FIFO_DEPTH];
    logic [3:0] wr_ptr_reg;
    logic [3:0] rd_ptr_reg;
    logic [4:0] lvl_reg;
    acd_pkg::acd_wstate_t ws_reg;
    acd_pkg::acd_wstate_t ws_next;

    wire full = lvl_reg == 5'(acd_pkg::FIFO_DEPTH);
    wire push = RESULT_VALID;
    wire pop = cs_fall & (ws_reg == acd_pkg::WS_IDLE) & (lvl_reg != 5'h00) & ~fifo_clr;
    wire inc = push & ~(full & ~pop); // [RULE21]
    wire rd_adv = pop | (push & full); // [RULE21]
    wire [3:0] wr_addr = fifo_clr ? 4'h0 : wr_ptr_reg;
    // A result arriving with a clear survives as the only entry.
    wire [3:0] wr_ptr_next = fifo_clr ? {3'h0, push} : wr_ptr_reg + {3'h0, push};
    wire [3:0] rd_ptr_next = fifo_clr ? 4'h0 : rd_ptr_reg + {3'h0, rd_adv};
    wire [4:0] lvl_next = fifo_clr ? {4'h0, push} : lvl_reg + {4'h0, inc} - {4'h0, pop};
    // An empty FIFO loads a zero result so the whole frame reads zero.
    wire [7:0] tx_res_next = pop ? mem[rd_ptr_reg] :
                             (cs_fall & ws_reg == acd_pkg::WS_IDLE) ? 8'h00 : tx_res_reg; // [RULE22]

    always_comb begin
        case (ws_reg)
            acd_pkg::WS_IDLE: ws_next = pop ? acd_pkg::WS_HELD : acd_pkg::WS_IDLE;
            acd_pkg::WS_HELD: ws_next = word_ev ? acd_pkg::WS_IDLE : acd_pkg::WS_HELD;
            default: ws_next = acd_pkg::WS_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (CE && push) begin
            mem[wr_addr] <= RESULT_DATA;
        end
    end

    // The result word is only changed at a select fall, well before the host's first falling edge.
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            wr_ptr_reg <= 4'h0;
            rd_ptr_reg <= 4'h0;
            lvl_reg <= 5'h00;
            tx_res_reg <= 8'h00;
            ws_reg <= acd_pkg::WS_IDLE;
        end else if (CE) begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            lvl_reg <= lvl_next;
            tx_res_reg <= tx_res_next;
            ws_reg <= ws_next;
        end
    end

    assign CHANNEL_NUMBER = conv_reg[acd_pkg::CH_HI:acd_pkg::CH_LO]; // [RULE2]
    assign SWEEP_KIND = conv_reg[acd_pkg::SWEEP_HI:acd_pkg::SWEEP_LO]; // [RULE3]
    assign SCAN_FIRST = first_reg;
    assign SCAN_LAST = last_reg;
    assign RESULT_COUNT = count_reg;
    assign CLOCKING_CHOICE = setup_reg[acd_pkg::CLK_HI:acd_pkg::CLK_LO];
    assign CONVERT_START_PIN_EN = ~setup_reg[acd_pkg::CLK_HI]; // [RULE6] [RULE7]
    assign REFERENCE_CHOICE = setup_reg[acd_pkg::REFC_HI:acd_pkg::REFC_LO]; // [RULE8]
    assign REF_POWER_ON = setup_reg[acd_pkg::REFC_HI] & ~setup_reg[acd_pkg::REFC_LO]; // [RULE8] [RULE15]
    assign AVERAGING_ENABLE = avg_reg[acd_pkg::AVG_EN_BIT];
    assign AVG_CONVERSIONS = avgc_reg;
    assign REPEAT_RESULT_COUNT = rep_reg;
    assign START_SCAN = start_reg;
    assign EOC_N = eoc_n_reg;
    assign FIFO_LEVEL = lvl_reg;

endmodule

// ### acd_spi_host.sv
`timescale 1ns/1ps
module acd_spi_host (
    // Link pins toward the device.
    output logic sclk,
    output logic cs_n,
    output logic din,
    // Serial data from the device.
    input wire logic dout
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b1;
    end

    // SCLK idles low, so the link clock only runs inside a frame.
    task automatic frame(input logic [15:0] tx, input int nb, output logic [15:0] rx);
        rx = 16'h0000;
        #3 cs_n = 1'b0;
        #32;
        for (int i = 0; i < nb; i++) begin
            din = tx[15 - i];
            #16;
            rx[15 - i] = dout;
            sclk = 1'b1;
            #16 sclk = 1'b0;
        end
        #16 cs_n = 1'b1;
        // A released line shows the inverse of its last bit, so stale data never looks valid.
        din = ~din;
        #40;
    endtask
endmodule

// ### acd_decoder_assertions.sv
`timescale 1ns/1ps
module acd_decoder_assertions #(
    parameter int NUM_CHANNELS = 16
) (
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic NRST,
    // Observed pins.
    input wire logic CONVERT_START_N,
    input wire logic SCAN_DONE,
    input wire logic [3:0] CHANNEL_NUMBER,
    input wire logic [1:0] SWEEP_KIND,
    input wire logic [3:0] SCAN_FIRST,
    input wire logic [3:0] SCAN_LAST,
    input wire logic [1:0] CLOCKING_CHOICE,
    input wire logic CONVERT_START_PIN_EN,
    input wire logic [1:0] REFERENCE_CHOICE,
    input wire logic REF_POWER_ON,
    input wire logic AVERAGING_ENABLE,
    input wire logic [5:0] AVG_CONVERSIONS,
    input wire logic [4:0] REPEAT_RESULT_COUNT,
    input wire logic START_SCAN,
    input wire logic EOC_N,
    input wire logic [4:0] FIFO_LEVEL
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!NRST);
    avg_off_a: assert property (!AVERAGING_ENABLE |-> AVG_CONVERSIONS == 6'h01)
        else $error("averaging off but several conversions");
    avg_count_a: assert property (AVERAGING_ENABLE && CLOCKING_CHOICE != 2'h3 |->
        AVG_CONVERSIONS inside {6'h04, 6'h08, 6'h10, 6'h20}) else $error("bad average count");
    clk11_avg_a: assert property (CLOCKING_CHOICE == 2'h3 |-> AVG_CONVERSIONS == 6'h01)
        else $error("averaging in external clock mode");
    rep_count_a: assert property (REPEAT_RESULT_COUNT inside {5'h04, 5'h08, 5'h0c, 5'h10})
        else $error("bad repeat count");
    sweep_upto_a: assert property (SWEEP_KIND == 2'h0 |-> SCAN_FIRST == 4'h0 && SCAN_LAST == CHANNEL_NUMBER)
        else $error("bad upward scan range");
    sweep_from_a: assert property (SWEEP_KIND == 2'h1 |->
        SCAN_FIRST == CHANNEL_NUMBER && SCAN_LAST == 4'(NUM_CHANNELS - 1)) else $error("bad scan to top");
    pin_en_a: assert property (CONVERT_START_PIN_EN == !CLOCKING_CHOICE[1])
        else $error("shared pin role wrong");
    ref_on_a: assert property (REF_POWER_ON == (REFERENCE_CHOICE == 2'h2))
        else $error("reference power wrong");
    ref_rsvd_a: assert property (REFERENCE_CHOICE != 2'h3)
        else $error("reserved reference stored");
    eoc_clk11_a: assert property (CLOCKING_CHOICE == 2'h3 |-> EOC_N)
        else $error("end of conversion low in clock mode 11");
    eoc_done_a: assert property (SCAN_DONE && CLOCKING_CHOICE != 2'h3 |=> !EOC_N)
        else $error("end of conversion not flagged");
    pin_start_a: assert property ($fell(CONVERT_START_N) && CONVERT_START_PIN_EN |-> ##[3:6] START_SCAN)
        else $error("pin start ignored");
    start_pulse_a: assert property (START_SCAN |=> !START_SCAN)
        else $error("scan request longer than one cycle");
    fifo_cap_a: assert property (FIFO_LEVEL <= 5'h10)
        else $error("fifo level above depth");
    cover property (START_SCAN);
    cover property (FIFO_LEVEL == 5'h10);
    cover property (!EOC_N);
endmodule

bind acd_decoder acd_decoder_assertions #(.NUM_CHANNELS(NUM_CHANNELS)) chk (.*);

// ### acd_decoder_tb.sv
`timescale 1ns/1ps
module acd_decoder_tb;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic cnv_n = 1'b1;
    logic res_valid = 1'b0;
    logic [7:0] res_data = 8'h00;
    logic scan_done = 1'b0;
    logic sclk, cs_n, din, dout, pin_en, ref_on, avg_en, start, eoc_n;
    logic [3:0] ch, sfirst, slast;
    logic [1:0] sweep, clk_sel, ref_sel;
    logic [4:0] rcnt, rep, level;
    logic [5:0] avg;
    logic [15:0] rx;
    logic [4:0] ecnt [4] = '{5'h06, 5'h0b, 5'h04, 5'h01};
    int num_errors = 0;
    int total_checks = 0;
    int starts = 0;
    int s;

    always #2.5 ref_clk = ~ref_clk;

    // Full sixteen-input variant, so every channel number is legal.
    acd_decoder #(.NUM_CHANNELS(16)) dut (
        .REF_CLK(ref_clk), .NRST(nrst), .CE(ce), .SCLK(sclk), .CS_N(cs_n), .DIN(din), .DOUT(dout),
        .CONVERT_START_N(cnv_n), .RESULT_VALID(res_valid), .RESULT_DATA(res_data), .SCAN_DONE(scan_done),
        .CHANNEL_NUMBER(ch), .SWEEP_KIND(sweep), .SCAN_FIRST(sfirst), .SCAN_LAST(slast), .RESULT_COUNT(rcnt),
        .CLOCKING_CHOICE(clk_sel), .CONVERT_START_PIN_EN(pin_en), .REFERENCE_CHOICE(ref_sel),
        .REF_POWER_ON(ref_on), .AVERAGING_ENABLE(avg_en), .AVG_CONVERSIONS(avg),
        .REPEAT_RESULT_COUNT(rep), .START_SCAN(start), .EOC_N(eoc_n), .FIFO_LEVEL(level));
    acd_spi_host host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

    always @(posedge ref_clk) if (start === 1'b1) starts <= starts + 1;

    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] b);
        // A zero second byte selects no register and keeps the output word position aligned.
        host.frame({b, 8'h00}, 16, rx);
        repeat (8) @(posedge ref_clk);
    endtask
    task automatic rd(input logic [15:0] e);
        host.frame(16'h0000, 16, rx);
        repeat (8) @(posedge ref_clk);
        chk("frame", e, rx);
    endtask
    task automatic push(input logic [7:0] d);
        @(posedge ref_clk);
        res_valid <= 1'b1;
        res_data <= d;
        @(posedge ref_clk);
        res_valid <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic pulse_done;
        @(posedge ref_clk);
        scan_done <= 1'b1;
        @(posedge ref_clk);
        scan_done <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic chk_dflt;
        chk("defaults", {2'h2, 2'h0, 1'b0, 4'h0, 2'h0, 1'b0, 5'h04, 5'h00},
            {clk_sel, ref_sel, ref_on, ch, sweep, avg_en, rep, level});
    endtask
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #300000;
        num_errors++;
        stop_test;
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk_dflt;
        for (int m = 0; m < 4; m++) begin
            wr({1'b1, 4'h5, m[1:0], 1'b1});
            chk("scan", {4'h5, m[1:0], ((m == 0) ? 4'h0 : 4'h5), ((m == 1) ? 4'hf : 4'h5), ecnt[m]},
                {ch, sweep, sfirst, slast, rcnt});
            chk("starts", 24'(m + 1), 24'(starts));
        end
        wr(8'hfa);
        chk("scan", {4'hf, 2'h1, 4'hf, 4'hf, 5'h01}, {ch, sweep, sfirst, slast, rcnt});
        for (int k = 0; k < 4; k++) begin
            wr(8'h30 | 8'(k * 5));
            chk("avg", {1'b1, 6'h04 << k, 5'(4 * k + 4)}, {avg_en, avg, rep});
        end
        wr(8'hac);
        chk("repeat", 5'h10, rcnt);
        wr(8'h2c);
        chk("avg", {1'b0, 6'h01, 5'h04}, {avg_en, avg, rep});
        wr(8'h3c);
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 3; r++) begin
                wr({2'b01, c[1:0], r[1:0], 2'b11});
                chk("setup", {c[1:0], ~c[1], r[1:0], r == 2}, {clk_sel, pin_en, ref_sel, ref_on});
                chk("avg", (c == 3) ? 6'h01 : 6'h20, avg);
                if (c == 3) begin
                    pulse_done;
                    chk("eoc", 1'b1, eoc_n);
                end
            end
        end
        wr(8'h6c);
        chk("rsvd", {2'h2, 2'h2}, {clk_sel, ref_sel});
        pulse_done;
        chk("eoc", 1'b0, eoc_n);
        rd(16'h0000);
        chk("eoc", 1'b1, eoc_n);
        push(8'h5a);
        chk("level", 5'h01, level);
        rd(16'h05a0);
        chk("level", 5'h00, level);
        for (int i = 1; i < 18; i++) push(8'(i));
        chk("level", 5'h10, level);
        rd(16'h0020);
        wr(8'h1f);
        chk("clear", {5'h00, 2'h2, 2'h2}, {level, clk_sel, ref_sel});
        wr(8'h40);
        s = starts;
        wr(8'h84);
        chk("starts", 24'(s), 24'(starts));
        cnv_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        cnv_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk("starts", 24'(s + 1), 24'(starts));
        push(8'h11);
        wr(8'h17);
        chk_dflt;
        stop_test;
    end
endmodule
